// [abp_pkg.sv]
// package: register map, reset values, field positions and carriers for the base page registers
//
// Notes on behaviour
// - codeword D15 follows local next-page register bit
// - local ack D14 read-only, reads zero
// - writable remote-fault bit sent in D13
// - pause capability field in D12:D10, reset 100
// - echo written nonce until exchange, then partner's
// - echo field reads back written value only
// - selector field in D4:D0, reset 00001
// - technology bits 10:3 sent in D31:D24
// - 10G technology bit in D23, resets one
// - reserved technology bit D22 always zero
// - 1G technology bit in D21, resets zero
// - sent nonce from hardware random generator
// - FEC request bit sent in D47
// - FEC ability bit sent in D46, resets one
// - technology bits 24:11 sent in D45:D32
// - partner register captures received base page
// - partner next-page and fault flags read directly
// - partner selector reads 00001, reset 0x0001
package abp_pkg;

   // management addressing
   localparam logic [4:0]  DEV_ADDR      = 5'h07;
   localparam logic [15:0] OFS_LOCAL_W0  = 16'h0010;
   localparam logic [15:0] OFS_LOCAL_W1  = 16'h0011;
   localparam logic [15:0] OFS_LOCAL_W2  = 16'h0012;
   localparam logic [15:0] OFS_PARTNER_0 = 16'h0013;

   // reset values
   localparam logic [15:0] RST_LOCAL_W0  = 16'h1001;
   localparam logic [15:0] RST_LOCAL_W1  = 16'h0080;
   localparam logic [15:0] RST_LOCAL_W2  = 16'h4000;
   localparam logic [15:0] RST_PARTNER_0 = 16'h0001;
   localparam logic [15:0] RST_TOKEN_GEN = 16'hACE1;  // any non-zero seed

   // field positions in local word0 / partner word0
   localparam int ACK_BIT      = 14;
   localparam int ECHO_LSB     = 5;
   localparam int ECHO_MSB     = 9;
   localparam int SEL_MSB      = 4;
   localparam logic [4:0] PARTNER_SEL = 5'h01;

   // writable masks; clear bits are held at zero
   localparam logic [15:0] MASK_W0 = 16'hBFFF;   // ack never stored
   localparam logic [15:0] MASK_W1 = 16'hFFBF;   // reserved tech bit held low
   localparam logic [15:0] MASK_W2 = 16'hFFFF;

   // field positions in local word1 and codeword
   localparam int NONCE_MSB    = 4;
   localparam int CW_NONCE_LSB = 16;
   localparam int CW_NONCE_MSB = 20;
   localparam int CW_W2_LSB    = 32;
   localparam int CW_RSV_BIT   = 22;

   // management request carrier, one decoded Clause 45 access
   typedef struct packed {
      logic        valid;   // one-cycle request strobe
      logic        write;   // 1 write, 0 read
      logic [4:0]  dev;     // device address
      logic [15:0] addr;    // register address
      logic [15:0] wdata;   // write data
   } abp_mgmt_req_t;

endpackage : abp_pkg

// [abp_base_page_regs.sv]
// base page advertisement registers and transmitted codeword assembly
`timescale 1ns/10ps
`default_nettype none

module abp_base_page_regs (
   input  wire logic                   clk_in,              // 20 MHz management clock
   input  wire logic                   rst_in,              // async, active high
   input  wire abp_pkg::abp_mgmt_req_t mgmt_req_in,         // decoded management access
   output logic [15:0]                 mgmt_rdata_out,      // read data
   output logic                        mgmt_rvalid_out,     // read data strobe
   input  wire logic                   an_start_in,         // negotiation start/restart pulse
   input  wire logic                   nonce_exchanged_in,  // unique nonces exchanged level
   input  wire logic [4:0]             partner_nonce_in,    // partner transmitted nonce
   input  wire logic                   partner_page_in_vld, // partner page received pulse
   input  wire logic [15:0]            partner_page_in,     // partner page D15:D0
   output logic [47:0]                 codeword_out         // base codeword to transmit
);

   logic [15:0] local_w0;      // local_base_page_word0 storage
   logic [15:0] local_w1;      // local_base_page_word1 storage
   logic [15:0] local_w2;      // local_base_page_word2 storage
   logic [15:0] partner_w0;    // partner_base_page_word0 capture
   logic [15:0] token_gen;     // random token generator state
   logic [15:0] rd_addr;       // address of the last read, for checks
   logic        hit;           // request is for this device
   logic [15:0] next_rdata;    // read mux output

   assign hit = mgmt_req_in.valid && (mgmt_req_in.dev == abp_pkg::DEV_ADDR);

   // software writes; masked bits never store, so ack and reserved tech stay 0
   // masking at the store keeps the read path a plain mux, with no per-field
   // read-only logic and no chance of a stale one showing up later
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         local_w0 <= abp_pkg::RST_LOCAL_W0;
         local_w1 <= abp_pkg::RST_LOCAL_W1;
         local_w2 <= abp_pkg::RST_LOCAL_W2;
      end else if (hit && mgmt_req_in.write) begin
         unique case (mgmt_req_in.addr)
            abp_pkg::OFS_LOCAL_W0: begin
               local_w0 <= mgmt_req_in.wdata & abp_pkg::MASK_W0;
            end
            abp_pkg::OFS_LOCAL_W1: begin
               local_w1 <= mgmt_req_in.wdata & abp_pkg::MASK_W1;
            end
            abp_pkg::OFS_LOCAL_W2: begin
               local_w2 <= mgmt_req_in.wdata & abp_pkg::MASK_W2;
            end
            default: begin
               // partner word and unmapped addresses ignore writes
            end
         endcase
      end
   end

   // partner page capture; selector forced so reads always show 00001
   // only word0 of the partner page lives here; higher words belong elsewhere
   // forcing the selector hides a partner that sends a foreign selector
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         partner_w0 <= abp_pkg::RST_PARTNER_0;
      end else if (partner_page_in_vld) begin
         partner_w0 <= {partner_page_in[15:abp_pkg::SEL_MSB+1], abp_pkg::PARTNER_SEL};
      end
   end

   // free-running lfsr; keeps moving so restarts draw fresh tokens
   // two ends leaving reset together draw equal tokens at equal times;
   // the restart instant is what separates them, not the seed
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         token_gen <= abp_pkg::RST_TOKEN_GEN;
      end else begin
         token_gen <= {token_gen[14:0],
                       token_gen[15] ^ token_gen[13] ^ token_gen[12] ^ token_gen[10]};
      end
   end

   // read mux; unmapped addresses in this device read as zero
   // written nonce field reads back as stored, never the generated token
   // echo field likewise reads the written value, not what is on the link
   always_comb begin
      unique case (mgmt_req_in.addr)
         abp_pkg::OFS_LOCAL_W0:  next_rdata = local_w0;
         abp_pkg::OFS_LOCAL_W1:  next_rdata = local_w1;
         abp_pkg::OFS_LOCAL_W2:  next_rdata = local_w2;
         abp_pkg::OFS_PARTNER_0: next_rdata = partner_w0;
         default:                next_rdata = 16'h0000;
      endcase
   end

   // read answer one cycle after the request; other devices get no answer
   // rdata holds between answers so a slow host may sample it late
   // rd_addr only tags the answer for the checks below
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mgmt_rdata_out  <= 16'h0000;
         mgmt_rvalid_out <= 1'b0;
         rd_addr         <= 16'h0000;
      end else begin
         mgmt_rvalid_out <= hit && !mgmt_req_in.write;
         if (hit && !mgmt_req_in.write) begin
            mgmt_rdata_out <= next_rdata;
            rd_addr        <= mgmt_req_in.addr;
         end
      end
   end

   // codeword: snapshot at start, echo field tracks exchange state after that
   // writes between restarts do not reach the link until the next start,
   // so a page in flight never changes under the partner; the echo field is
   // the one exception, it must follow the exchange state at once
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         codeword_out <= 48'h0000_0000_0000;
      end else begin
         if (an_start_in) begin
            codeword_out[47:abp_pkg::CW_W2_LSB] <= local_w2;
            codeword_out[31:abp_pkg::CW_RSV_BIT+1] <= local_w1[15:7];
            codeword_out[abp_pkg::CW_RSV_BIT] <= 1'b0;
            codeword_out[abp_pkg::CW_RSV_BIT-1] <= local_w1[5];
            codeword_out[abp_pkg::CW_NONCE_MSB:abp_pkg::CW_NONCE_LSB]
               <= token_gen[abp_pkg::NONCE_MSB:0];
            codeword_out[15] <= local_w0[15];
            codeword_out[abp_pkg::ACK_BIT] <= 1'b0;                 // hardware owns ack
            codeword_out[13:10] <= local_w0[13:10];
            codeword_out[abp_pkg::SEL_MSB:0] <= local_w0[abp_pkg::SEL_MSB:0];
         end
         // echo: written value until exchange, then partner's token
         if (nonce_exchanged_in) begin
            codeword_out[abp_pkg::ECHO_MSB:abp_pkg::ECHO_LSB] <= partner_nonce_in;
         end else begin
            codeword_out[abp_pkg::ECHO_MSB:abp_pkg::ECHO_LSB]
               <= local_w0[abp_pkg::ECHO_MSB:abp_pkg::ECHO_LSB];
         end
      end
   end

   // checks
   // all checks run on the one management clock and stop during reset
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // next-page bit goes out as written
   a_np_sent_start: assert property (an_start_in |=> codeword_out[15] == $past(local_w0[15]))
      else $error("next-page bit not sent from register");

   // ack field never reads back as one
   a_ack_reads_zero: assert property (
      mgmt_rvalid_out && rd_addr == abp_pkg::OFS_LOCAL_W0 |-> !mgmt_rdata_out[abp_pkg::ACK_BIT])
      else $error("local ack bit read as one");

   // fault, pause caps and selector go out as written
   a_caps_sel_sent: assert property (
      an_start_in |=> codeword_out[13:10] == $past(local_w0[13:10])
                      && codeword_out[4:0] == $past(local_w0[4:0]))
      else $error("fault, caps or selector not sent");

   // after the exchange the partner token is echoed
   a_echo_partner: assert property (
      nonce_exchanged_in |=> codeword_out[9:5] == $past(partner_nonce_in))
      else $error("echo not switched to partner token");

   // before the exchange the written echo value goes out
   a_echo_written: assert property (
      !nonce_exchanged_in ##1 !nonce_exchanged_in |-> codeword_out[9:5] == $past(local_w0[9:5]))
      else $error("echo not taken from written value");

   // echo field reads the stored value
   a_echo_readback: assert property (
      hit && !mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W0
      |=> mgmt_rvalid_out && mgmt_rdata_out[9:5] == $past(local_w0[9:5]))
      else $error("echo readback differs from written value");

   // reserved technology bit is never sent
   a_tech_rsv_zero: assert property (codeword_out[abp_pkg::CW_RSV_BIT] == 1'b0)
      else $error("reserved technology bit sent as one");

   // sent nonce comes from the generator, tech bits from word1
   a_token_random: assert property (
      an_start_in |=> codeword_out[20:16] == $past(token_gen[4:0])
                      && codeword_out[31:21] == $past({local_w1[15:7], 1'b0, local_w1[5]}))
      else $error("nonce or technology bits wrong");

   // fec request, fec ability and upper tech bits go out from word2
   a_fec_sent: assert property (
      an_start_in |=> codeword_out[47:32] == $past(local_w2))
      else $error("word2 fields not sent");

   // partner page captured on its strobe
   a_partner_cap: assert property (
      partner_page_in_vld |=> partner_w0[15:5] == $past(partner_page_in[15:5]))
      else $error("partner page not captured");

   // partner selector reads as one
   a_partner_sel: assert property (
      mgmt_rvalid_out && rd_addr == abp_pkg::OFS_PARTNER_0 |-> mgmt_rdata_out[4:0] == 5'h01)
      else $error("partner selector not 00001");

   // read answer exactly one cycle after each read for this device
   a_rvalid_follows: assert property (
      mgmt_rvalid_out == $past(hit && !mgmt_req_in.write))
      else $error("read strobe not one cycle after read");

   // accesses for other devices get no answer
   a_other_dev_quiet: assert property (
      mgmt_req_in.valid && mgmt_req_in.dev != abp_pkg::DEV_ADDR |=> !mgmt_rvalid_out)
      else $error("answer to another device address");

   // unmapped addresses read as zero
   a_unmapped_zero: assert property (
      mgmt_rvalid_out && (rd_addr < abp_pkg::OFS_LOCAL_W0 || rd_addr > abp_pkg::OFS_PARTNER_0)
      |-> mgmt_rdata_out == 16'h0000)
      else $error("unmapped address read as non-zero");

   // read data holds between answers
   a_rdata_hold: assert property (!mgmt_rvalid_out |-> $stable(mgmt_rdata_out))
      else $error("read data moved without an answer");

   // word0 write stores masked data
   a_w0_write: assert property (
      hit && mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W0
      |=> local_w0 == $past(mgmt_req_in.wdata & abp_pkg::MASK_W0))
      else $error("word0 write not stored");

   // word1 write stores masked data
   a_w1_write: assert property (
      hit && mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W1
      |=> local_w1 == $past(mgmt_req_in.wdata & abp_pkg::MASK_W1))
      else $error("word1 write not stored");

   // word2 write stores data
   a_w2_write: assert property (
      hit && mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W2
      |=> local_w2 == $past(mgmt_req_in.wdata & abp_pkg::MASK_W2))
      else $error("word2 write not stored");

   // word0 only changes on its own write
   a_w0_hold: assert property (
      !(hit && mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W0)
      |=> $stable(local_w0))
      else $error("word0 changed without a write");

   // word1 only changes on its own write
   a_w1_hold: assert property (
      !(hit && mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W1)
      |=> $stable(local_w1))
      else $error("word1 changed without a write");

   // word2 only changes on its own write
   a_w2_hold: assert property (
      !(hit && mgmt_req_in.write && mgmt_req_in.addr == abp_pkg::OFS_LOCAL_W2)
      |=> $stable(local_w2))
      else $error("word2 changed without a write");

   // ack and reserved tech bits never store
   a_masked_zero: assert property (
      (local_w0 & ~abp_pkg::MASK_W0) == 16'h0000 && (local_w1 & ~abp_pkg::MASK_W1) == 16'h0000)
      else $error("read-only bit stored as one");

   // generator never locks up at zero
   a_token_nonzero: assert property (token_gen != 16'h0000)
      else $error("token generator stuck at zero");

   // partner word only changes on a received page, writes included
   a_partner_hold: assert property (!partner_page_in_vld |=> $stable(partner_w0))
      else $error("partner word changed without a page");

   // stored partner selector always one
   a_partner_sel_reg: assert property (
      partner_w0[abp_pkg::SEL_MSB:0] == abp_pkg::PARTNER_SEL)
      else $error("stored partner selector not 00001");

   // partner next-page, fault and other flags read straight from capture
   a_partner_read: assert property (
      mgmt_rvalid_out && rd_addr == abp_pkg::OFS_PARTNER_0
      |-> mgmt_rdata_out[15:5] == $past(partner_w0[15:5]))
      else $error("partner flags read wrong");

   // fields other than echo only move at a start
   a_fields_hold: assert property (
      !an_start_in |=> $stable(codeword_out[47:10]) && $stable(codeword_out[4:0]))
      else $error("codeword moved without a start");

   // main scenarios
   c_start: cover property (an_start_in ##1 !an_start_in);
   c_partner_read: cover property (partner_page_in_vld ##[1:8] mgmt_rvalid_out
                                   && rd_addr == abp_pkg::OFS_PARTNER_0);
   c_exchange: cover property (!nonce_exchanged_in ##1 nonce_exchanged_in);
   c_start_exchanged: cover property (an_start_in && nonce_exchanged_in);
   c_unmapped_read: cover property (mgmt_rvalid_out && rd_addr > abp_pkg::OFS_PARTNER_0);

endmodule // abp_base_page_regs

`default_nettype wire

// [abp_link_partner.sv]
// behavioural link partner: sends base pages and its own nonce
`timescale 1ns/10ps
`default_nettype none
module abp_link_partner (
   input  wire logic        clk_in,       // management clock
   input  wire logic        rst_in,       // async, active high
   input  wire logic        send_in,      // bench asks for one page
   input  wire logic [15:0] page_in,      // page D15:D0 to send
   input  wire logic [4:0]  nonce_in,     // partner own nonce
   input  wire logic        xchg_in,      // nonces exchanged
   output logic             page_vld_out, // one-cycle page strobe
   output logic [15:0]      page_out,     // page bits, junk when idle
   output logic [4:0]       nonce_out,    // transmitted nonce
   output logic             xchg_out      // exchange done level
);
   // page strobe; idle data flips so a stale page never passes for fresh
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         page_vld_out <= 1'b0;
         page_out     <= 16'h0000;
      end else begin
         page_vld_out <= send_in;
         page_out     <= send_in ? page_in : ~page_out;
      end
   end
   // nonce and exchange state, plain levels
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         nonce_out <= 5'h00;
         xchg_out  <= 1'b0;
      end else begin
         nonce_out <= nonce_in;
         xchg_out  <= xchg_in;
      end
   end
endmodule // abp_link_partner
`default_nettype wire

// [test_autoneg_base_page_regs.sv]
// self-checking bench for the base page register block
`timescale 1ns/10ps
`default_nettype none
module test_autoneg_base_page_regs;
   logic                   clk_in, rst_in, an_start, send, xchg, pvld, pxchg, rvalid;
   abp_pkg::abp_mgmt_req_t req;          // management access
   logic [15:0]            rdata, pg, ppage;
   logic [4:0]             nce, pnonce;  // partner nonce, bench and wire
   logic [47:0]            cw;           // transmitted codeword
   logic [31:0]            r;            // random scratch
   logic [15:0]            m [4];        // model of 0x10..0x13
   int                     num_errors = 0, total_checks = 0, cyc = 0;
   integer                 seed;
   abp_base_page_regs abp_base_page_regs_i (.clk_in(clk_in), .rst_in(rst_in),
      .mgmt_req_in(req), .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
      .an_start_in(an_start), .nonce_exchanged_in(pxchg), .partner_nonce_in(pnonce),
      .partner_page_in_vld(pvld), .partner_page_in(ppage), .codeword_out(cw));
   abp_link_partner abp_link_partner_i (.clk_in(clk_in), .rst_in(rst_in), .send_in(send),
      .page_in(pg), .nonce_in(nce), .xchg_in(xchg), .page_vld_out(pvld),
      .page_out(ppage), .nonce_out(pnonce), .xchg_out(pxchg));
   // 20 MHz clock
   always #25 clk_in = ~clk_in;
   // hang guard, under two hundred cycles expected
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         results();
      end
   end
   task automatic results;
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one access, valid for exactly one cycle; model follows mapped writes
   task automatic acc(input logic wr, input logic [4:0] dv, input logic [15:0] a,
                      input logic [15:0] d);
      @(posedge clk_in) req <= '{1'b1, wr, dv, a, d};
      @(posedge clk_in) req.valid <= 1'b0;
      if (wr && dv == 5'h07 && a >= 16'h10 && a <= 16'h12)
         m[a[1:0]] = d & (a[1:0] == 2'd0 ? 16'hBFFF : a[1:0] == 2'd1 ? 16'hFFBF : 16'hFFFF);
   endtask
   task automatic rd(input logic [15:0] a);
      acc(1'b0, 5'h07, a, 16'h0000);
      #1 chk({47'h0, rvalid}, 48'h1);
      chk({32'h0, rdata}, (a >= 16'h10 && a <= 16'h13) ? {32'h0, m[a[1:0]]} : 48'h0);
   endtask
   // partner sends a page; captured selector always reads one
   task automatic lp(input logic [15:0] p);
      @(posedge clk_in) begin
         send <= 1'b1;
         pg   <= p;
      end
      @(posedge clk_in) send <= 1'b0;
      @(posedge clk_in) m[3] = {p[15:5], 5'h01};
   endtask
   // restart negotiation; random nonce bits are masked, hardware picks them
   task automatic start;
      @(posedge clk_in) an_start <= 1'b1;
      @(posedge clk_in) an_start <= 1'b0;
      #1 chk(cw & ~48'h0000001F0000, {m[2], m[1][15:7], 1'b0, m[1][5], 5'h00, m[0][15], 1'b0,
         m[0][13:10], xchg ? nce : m[0][9:5], m[0][4:0]});
   endtask
   initial begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      an_start = 1'b0;
      send = 1'b0;
      xchg = 1'b0;
      pg = 16'h0000;
      nce = 5'h00;
      req = '0;
      seed = 32'h212d;
      m = '{16'h1001, 16'h0080, 16'h4000, 16'h0001};
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      // reset values, partner word read first
      for (int i = 3; i >= 0; i--) rd(16'h10 + i[15:0]);
      start();
      acc(1'b1, 5'h06, 16'h10, 16'hFFFF);  // other device, ignored
      rd(16'h10);
      acc(1'b1, 5'h07, 16'h10, 16'hFFFF);
      acc(1'b1, 5'h07, 16'h11, 16'hFFFF);
      acc(1'b1, 5'h07, 16'h13, 16'h0000);  // read-only, ignored
      for (int i = 0; i < 4; i++) rd(16'h10 + i[15:0]);
      start();
      // random writes, pages and restarts, unmapped places included
      repeat (12) begin
         r = $random(seed);
         acc(1'b1, 5'h07, 16'h10 + {13'h0, r[2:0]}, r[31:16]);
         rd(16'h10 + {13'h0, r[2:0]});
         lp(r[23:8]);
         rd(16'h13);
         start();
      end
      // after the exchange the partner nonce is echoed, reads keep written value
      r = $random(seed);
      @(posedge clk_in) begin
         xchg <= 1'b1;
         nce  <= r[4:0];
      end
      repeat (3) @(posedge clk_in);
      start();
      rd(16'h10);
      results();
   end
endmodule // test_autoneg_base_page_regs
`default_nettype wire
